// [common/ccd_pkg.sv]
// Shared constants and types for the core datapath.
`default_nettype none
package ccd_pkg;
	localparam int DATA_W = 8;
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int LATCH_W = 5;
	localparam int FADDR_W = 9;
	localparam int PROG_WORDS_DEF = 8192;
	localparam int DRAM_DEPTH_DEF = 512;
	localparam int EXEC_CYCLES = 1;
	localparam int BRANCH_CYCLES = 2;
	// Core register offsets; only the low seven bits are decoded.
	localparam logic [8:0] OFS_INDIRECT = 9'h100;
	localparam logic [8:0] OFS_PCL = 9'h102;
	localparam logic [8:0] OFS_FLAGS = 9'h103;
	localparam logic [8:0] OFS_PTR = 9'h104;
	localparam logic [8:0] OFS_LATCH = 9'h10a;
	localparam logic [6:0] GPR_FIRST = 7'h20;
	// Flag register bit positions.
	localparam int FLG_C = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_PD = 3;
	localparam int FLG_TO = 4;
	localparam int FLG_RP0 = 5;
	localparam int FLG_RP1 = 6;
	localparam int FLG_IRP = 7;
	localparam logic [7:0] FLAGS_WMASK = 8'he7;
	localparam logic [7:0] FLAGS_KEEP = 8'h1f;
	// Reset values.
	localparam logic [7:0] FLAGS_POR = 8'h18;
	localparam logic [7:0] PTR_POR = 8'h00;
	localparam logic [7:0] W_POR = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [4:0] LATCH_RST = 5'h00;
	// Instruction groups and sub-opcodes.
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT = 2'h1;
	localparam logic [1:0] GRP_JUMP = 2'h2;
	localparam logic [1:0] GRP_LIT = 2'h3;
	localparam logic [3:0] BY_MOVWF = 4'h0;
	localparam logic [3:0] BY_CLR = 4'h1;
	localparam logic [3:0] BY_SUB = 4'h2;
	localparam logic [3:0] BY_DEC = 4'h3;
	localparam logic [3:0] BY_IOR = 4'h4;
	localparam logic [3:0] BY_AND = 4'h5;
	localparam logic [3:0] BY_XOR = 4'h6;
	localparam logic [3:0] BY_ADD = 4'h7;
	localparam logic [3:0] BY_MOV = 4'h8;
	localparam logic [3:0] BY_COM = 4'h9;
	localparam logic [3:0] BY_INC = 4'ha;
	localparam logic [3:0] BY_DECSKP = 4'hb;
	localparam logic [3:0] BY_RR = 4'hc;
	localparam logic [3:0] BY_RL = 4'hd;
	localparam logic [3:0] BY_SWAP = 4'he;
	localparam logic [3:0] BY_INCSKP = 4'hf;
	localparam logic [1:0] BI_CLR = 2'h0;
	localparam logic [1:0] BI_SET = 2'h1;
	localparam logic [3:0] LI_MOV = 4'b00??;
	localparam logic [3:0] LI_IOR = 4'h8;
	localparam logic [3:0] LI_AND = 4'h9;
	localparam logic [3:0] LI_XOR = 4'ha;
	localparam logic [3:0] LI_SUB = 4'b110?;
	localparam logic [3:0] LI_ADD = 4'b111?;
	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC,
		ALU_RL, ALU_RR, ALU_SWAP, ALU_PASSA, ALU_PASSB, ALU_ZERO, ALU_BCLR, ALU_BSET
	} ccd_alu_op_type;
endpackage
`default_nettype wire

// [common/ccd_alu_if.sv]
// Operand and result bundle between the core and its ALU.
`timescale 1ns/10ps
`default_nettype none
interface ccd_alu_if;
	import ccd_pkg::*;
	ccd_alu_op_type op;
	logic [7:0] a, b, y;
	logic [2:0] bit_sel;
	logic cin, c, dc, z;
	modport core (output op, a, b, bit_sel, cin, input y, c, dc, z);
	modport alu (input op, a, b, bit_sel, cin, output y, c, dc, z);
endinterface
`default_nettype wire

// [hw/ccd_alu.sv]
// Eight-bit arithmetic and logic unit.
`timescale 1ns/10ps
`default_nettype none
module ccd_alu (
	// Operands and results.
	ccd_alu_if.alu bus
);
	import ccd_pkg::*;
	logic [7:0] addend;
	logic cy;
	logic [8:0] sum;
	logic [4:0] nib;

	// Subtraction adds the inverted subtrahend plus one, so carries become not-borrows.
	always_comb begin
		case (bus.op)
			ALU_SUB: begin
				addend = ~bus.a;
				cy = 1'b1;
			end
			ALU_INC: begin
				addend = 8'h00;
				cy = 1'b1;
			end
			ALU_DEC: begin
				addend = 8'hff;
				cy = 1'b0;
			end
			default: begin
				addend = bus.a;
				cy = 1'b0;
			end
		endcase
		sum = {1'b0, bus.b} + {1'b0, addend} + {8'h00, cy};
		nib = {1'b0, bus.b[3:0]} + {1'b0, addend[3:0]} + {4'h0, cy};
	end

	// Result and carry selection.
	always_comb begin
		bus.c = bus.cin;
		bus.dc = nib[4];
		case (bus.op)
			ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC: begin
				bus.y = sum[7:0];
				bus.c = sum[8];
			end
			ALU_AND: bus.y = bus.a & bus.b;
			ALU_IOR: bus.y = bus.a | bus.b;
			ALU_XOR: bus.y = bus.a ^ bus.b;
			ALU_COM: bus.y = ~bus.b;
			ALU_RL: begin
				bus.y = {bus.b[6:0], bus.cin};
				bus.c = bus.b[7];
			end
			ALU_RR: begin
				bus.y = {bus.cin, bus.b[7:1]};
				bus.c = bus.b[0];
			end
			ALU_SWAP: bus.y = {bus.b[3:0], bus.b[7:4]};
			ALU_PASSA: bus.y = bus.a;
			ALU_ZERO: bus.y = 8'h00;
			ALU_BCLR: bus.y = bus.b & ~(8'h01 << bus.bit_sel);
			ALU_BSET: bus.y = bus.b | (8'h01 << bus.bit_sel);
			default: bus.y = bus.b;
		endcase
	end

	assign bus.z = (bus.y == 8'h00);
endmodule
`default_nettype wire

// [hw/ccd_dram.sv]
// General purpose data RAM behind the core register decode.
`timescale 1ns/10ps
`default_nettype none
module ccd_dram #(
	parameter int DEPTH = 512
) (
	// Clock.
	input wire logic clk,
	// Read port, combinational.
	input wire logic [8:0] rd_addr,
	output logic [7:0] rd_data,
	// Write port, taken at the clock edge.
	input wire logic we,
	input wire logic [8:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem [DEPTH];

	// Write on the edge that ends the executing instruction.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// [hw/ccd_core.sv]
// Core datapath: fetch/execute pipeline, working register, flags and core registers.
`timescale 1ns/10ps
`default_nettype none
module ccd_core #(
	parameter int PROG_WORDS = ccd_pkg::PROG_WORDS_DEF,
	parameter int DRAM_DEPTH = ccd_pkg::DRAM_DEPTH_DEF
) (
	// Clock and resets.
	input wire logic CLK,
	input wire logic RST,
	input wire logic BOR_RST,
	input wire logic EXT_RST,
	input wire logic WDOG_RST,
	// Program memory.
	output logic [ccd_pkg::PC_W-1:0] PROG_ADDR,
	input wire logic [ccd_pkg::INSTR_W-1:0] PROG_DATA,
	// Observation.
	output logic [ccd_pkg::DATA_W-1:0] WREG,
	output logic [ccd_pkg::DATA_W-1:0] FLAGS,
	output logic EXEC_VALID
);
	import ccd_pkg::*;

	localparam logic [12:0] PC_MASK = 13'(PROG_WORDS - 1);

	logic por, other_rst;
	logic [12:0] pc, next_pc;
	logic [13:0] ir;
	logic ir_valid;
	logic [7:0] w, flags, ptr;
	logic [4:0] latch;
	ccd_alu_op_type alu_op;
	logic use_lit, wr_f, wr_w, upd_z, upd_c, upd_dc;
	logic skip_zero, bit_test, jump;
	logic [8:0] eaddr;
	logic [6:0] reg_idx;
	logic [7:0] rd_data, ram_data;
	logic ram_hit, skip_taken, pcl_write, branch, ram_we;

	ccd_alu_if alu_bus ();

	ccd_alu u_alu (
		.bus(alu_bus)
	);

	// Power-on and brown-out share one set of values, the other resets another.
	assign por = RST | BOR_RST;
	assign other_rst = EXT_RST | WDOG_RST;

	// Decode of the word in the execute stage.
	always_comb begin
		alu_op = ALU_PASSB;
		use_lit = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		skip_zero = 1'b0;
		bit_test = 1'b0;
		jump = 1'b0;
		case (ir[13:12])
			GRP_BYTE: begin
				wr_f = ir[7];
				wr_w = !ir[7];
				case (ir[11:8])
					BY_MOVWF: begin
						alu_op = ALU_PASSA;
						wr_w = 1'b0;
					end
					BY_CLR: begin
						alu_op = ALU_ZERO;
						upd_z = 1'b1;
					end
					BY_SUB: begin
						alu_op = ALU_SUB;
						{upd_z, upd_c, upd_dc} = 3'h7;
					end
					BY_DEC: begin
						alu_op = ALU_DEC;
						upd_z = 1'b1;
					end
					BY_IOR: begin
						alu_op = ALU_IOR;
						upd_z = 1'b1;
					end
					BY_AND: begin
						alu_op = ALU_AND;
						upd_z = 1'b1;
					end
					BY_XOR: begin
						alu_op = ALU_XOR;
						upd_z = 1'b1;
					end
					BY_ADD: begin
						alu_op = ALU_ADD;
						{upd_z, upd_c, upd_dc} = 3'h7;
					end
					BY_MOV: upd_z = 1'b1;
					BY_COM: begin
						alu_op = ALU_COM;
						upd_z = 1'b1;
					end
					BY_INC: begin
						alu_op = ALU_INC;
						upd_z = 1'b1;
					end
					BY_DECSKP: begin
						alu_op = ALU_DEC;
						skip_zero = 1'b1;
					end
					BY_RR: begin
						alu_op = ALU_RR;
						upd_c = 1'b1;
					end
					BY_RL: begin
						alu_op = ALU_RL;
						upd_c = 1'b1;
					end
					BY_SWAP: alu_op = ALU_SWAP;
					BY_INCSKP: begin
						alu_op = ALU_INC;
						skip_zero = 1'b1;
					end
					default: alu_op = ALU_PASSB;
				endcase
			end
			GRP_BIT: begin
				case (ir[11:10])
					BI_CLR: begin
						alu_op = ALU_BCLR;
						wr_f = 1'b1;
					end
					BI_SET: begin
						alu_op = ALU_BSET;
						wr_f = 1'b1;
					end
					default: bit_test = 1'b1;
				endcase
			end
			GRP_JUMP: jump = ir[11];
			GRP_LIT: begin
				use_lit = 1'b1;
				wr_w = 1'b1;
				casez (ir[11:8])
					LI_MOV: alu_op = ALU_PASSB;
					LI_IOR: begin
						alu_op = ALU_IOR;
						upd_z = 1'b1;
					end
					LI_AND: begin
						alu_op = ALU_AND;
						upd_z = 1'b1;
					end
					LI_XOR: begin
						alu_op = ALU_XOR;
						upd_z = 1'b1;
					end
					LI_SUB: begin
						alu_op = ALU_SUB;
						{upd_z, upd_c, upd_dc} = 3'h7;
					end
					LI_ADD: begin
						alu_op = ALU_ADD;
						{upd_z, upd_c, upd_dc} = 3'h7;
					end
					default: wr_w = 1'b0;
				endcase
			end
			default: jump = 1'b0;
		endcase
	end

	// Address zero goes through the pointer; bank bits only reach general RAM.
	assign eaddr = (ir[6:0] == OFS_INDIRECT[6:0]) ? {flags[FLG_IRP], ptr}
		: {flags[FLG_RP1:FLG_RP0], ir[6:0]};
	assign reg_idx = eaddr[6:0];
	assign ram_hit = (reg_idx >= GPR_FIRST);

	ccd_dram #(
		.DEPTH(DRAM_DEPTH)
	) u_dram (
		.clk(CLK),
		.rd_addr(eaddr),
		.rd_data(ram_data),
		.we(ram_we),
		.wr_addr(eaddr),
		.wr_data(alu_bus.y)
	);

	// Register read decode; the pointer's self reference and holes read zero.
	always_comb begin
		case (reg_idx)
			OFS_PCL[6:0]: rd_data = pc[7:0];
			OFS_FLAGS[6:0]: rd_data = flags;
			OFS_PTR[6:0]: rd_data = ptr;
			OFS_LATCH[6:0]: rd_data = {3'h0, latch};
			default: rd_data = ram_hit ? ram_data : 8'h00;
		endcase
	end

	// The accumulator is always one operand; the other is file data or the literal.
	assign alu_bus.op = alu_op;
	assign alu_bus.a = w;
	assign alu_bus.b = use_lit ? ir[7:0] : rd_data;
	assign alu_bus.bit_sel = ir[9:7];
	assign alu_bus.cin = flags[FLG_C];

	// Branch detection: jumps, writes to the counter low byte and taken skips.
	assign pcl_write = wr_f && (reg_idx == OFS_PCL[6:0]);
	assign skip_taken = (skip_zero && alu_bus.z)
		|| (bit_test && (rd_data[ir[9:7]] == ir[10]));
	assign branch = ir_valid && (jump || pcl_write || skip_taken);
	assign ram_we = ir_valid && wr_f && ram_hit;

	// Next fetch address; the latch supplies the bits above the low byte on a counter write, and bits 12:11 on a jump.
	always_comb begin
		if (ir_valid && jump) begin
			next_pc = {latch[4:3], ir[10:0]};
		end else if (ir_valid && pcl_write) begin
			next_pc = {latch, alu_bus.y};
		end else begin
			next_pc = pc + 13'h0001;
		end
		next_pc = next_pc & PC_MASK;
	end

	// Fetch stage loads one word per cycle while the previous one executes.
	always_ff @(posedge CLK) begin
		if (por || other_rst) begin
			pc <= PC_RST;
			ir <= 14'h0000;
			ir_valid <= 1'b0;
		end else begin
			pc <= next_pc;
			ir <= PROG_DATA;
			ir_valid <= !branch;
		end
	end

	// Working register; kept across the other resets.
	always_ff @(posedge CLK) begin
		if (por) begin
			w <= W_POR;
		end else if (!other_rst && ir_valid && wr_w) begin
			w <= alu_bus.y;
		end
	end

	// Flag register: software writes, then ALU flag updates take priority.
	always_ff @(posedge CLK) begin
		if (por) begin
			flags <= FLAGS_POR;
		end else if (other_rst) begin
			flags <= flags & FLAGS_KEEP;
		end else if (ir_valid) begin
			if (wr_f && reg_idx == OFS_FLAGS[6:0]) begin
				flags <= (alu_bus.y & FLAGS_WMASK) | (flags & ~FLAGS_WMASK);
			end
			if (upd_z) begin
				flags[FLG_Z] <= alu_bus.z;
			end
			if (upd_c) begin
				flags[FLG_C] <= alu_bus.c;
			end
			if (upd_dc) begin
				flags[FLG_DC] <= alu_bus.dc;
			end
		end
	end

	// Indirect pointer; kept across the other resets.
	always_ff @(posedge CLK) begin
		if (por) begin
			ptr <= PTR_POR;
		end else if (!other_rst && ir_valid && wr_f && reg_idx == OFS_PTR[6:0]) begin
			ptr <= alu_bus.y;
		end
	end

	// Counter high latch; only five bits are stored.
	always_ff @(posedge CLK) begin
		if (por || other_rst) begin
			latch <= LATCH_RST;
		end else if (ir_valid && wr_f && reg_idx == OFS_LATCH[6:0]) begin
			latch <= alu_bus.y[4:0];
		end
	end

	assign PROG_ADDR = pc;
	assign WREG = w;
	assign FLAGS = flags;
	assign EXEC_VALID = ir_valid;

	// Checks on the datapath; reset is taken as sampled, so the edge that releases it is skipped.
	default clocking cb @(posedge CLK); endclocking
	default disable iff ($sampled(por || other_rst));

	sequence s_branch;
		branch;
	endsequence

	sequence s_bubble_then_run;
		!ir_valid ##1 ir_valid;
	endsequence

	a_add_twos: assert property (
		(ir_valid && alu_op == ALU_ADD)
		|-> ({alu_bus.c, alu_bus.y} == {1'b0, w} + {1'b0, alu_bus.b}))
		else $error("Addition result or carry wrong.");

	a_sub_borrow: assert property (
		(ir_valid && alu_op == ALU_SUB && upd_c)
		|=> (flags[FLG_C] == ($past(alu_bus.b) >= $past(w))))
		else $error("Subtract carry is not the inverted borrow.");

	a_zero_flag: assert property (
		(ir_valid && upd_z) |=> (flags[FLG_Z] == ($past(alu_bus.y) == 8'h00)))
		else $error("Zero flag does not match result.");

	a_fetch_step: assert property (
		(!branch && pc != PC_MASK) |=> (pc == $past(pc) + 13'h0001) && ir_valid)
		else $error("Non-branch did not advance one word.");

	a_fetch_word: assert property (
		1'b1 |=> (ir == $past(PROG_DATA)))
		else $error("Fetched word not captured.");

	a_branch_flush: assert property (
		s_branch |=> s_bubble_then_run)
		else $error("Branch did not discard exactly one word.");

	a_jump_latch: assert property (
		(ir_valid && jump) |=> (pc == (({$past(latch[4:3]), $past(ir[10:0])}) & PC_MASK)))
		else $error("Jump target not formed from the latch.");

	a_indirect_addr: assert property (
		(ir[6:0] == 7'h00) |-> (eaddr == {flags[FLG_IRP], ptr})
		&& ((ptr[6:0] != 7'h00) || (rd_data == 8'h00)))
		else $error("Indirect access not routed through pointer.");

	a_unimpl_zero: assert property (
		(!ram_hit && reg_idx != OFS_PCL[6:0] && reg_idx != OFS_FLAGS[6:0]
		&& reg_idx != OFS_PTR[6:0] && reg_idx != OFS_LATCH[6:0]) |-> (rd_data == 8'h00))
		else $error("Unimplemented location did not read zero.");

	a_pc_range: assert property (
		(pc & ~PC_MASK) == 13'h0000)
		else $error("Program counter beyond memory size.");

	a_other_keeps_w: assert property (
		@(posedge CLK) disable iff (1'b0)
		(other_rst && !por) |=> (w == $past(w)) && (pc == PC_RST) && !ir_valid)
		else $error("Other reset disturbed the accumulator.");

	a_por_values: assert property (
		@(posedge CLK) disable iff (1'b0)
		por |=> (flags == FLAGS_POR) && (w == W_POR) && (latch == LATCH_RST))
		else $error("Power-on values not applied.");
endmodule
`default_nettype wire

// [bench/ccd_prog_model.sv]
// Program memory model that answers every fetch within the same cycle.
`timescale 1ns/10ps
`default_nettype none
module ccd_prog_model #(
	parameter int WORDS = 8192
) (
	// Fetch port.
	input wire logic [ccd_pkg::PC_W-1:0] addr,
	output logic [ccd_pkg::INSTR_W-1:0] data
);
	import ccd_pkg::*;
	logic [13:0] mem [WORDS];
	// One whole word is returned for every fetch address, with no wait.
	assign data = mem[addr];
endmodule
`default_nettype wire

// [bench/ccd_core_tb.sv]
// Self-checking bench for the core datapath.
`timescale 1ns/10ps
`default_nettype none
module ccd_core_tb;
	import ccd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bor_rst = 1'b0;
	logic ext_rst = 1'b0;
	logic wdog_rst = 1'b0;
	logic [12:0] prog_addr;
	logic [13:0] prog_data;
	logic [7:0] wreg;
	logic [7:0] flags;
	logic exec_valid;
	int fail_count = 0;
	int tests_run = 0;
	int k;
	logic [7:0] ra, rb, ey, ef;
	logic [2:0] fl, fm;
	logic [3:0] op;
	logic [3:0] byops [13] = '{BY_CLR, BY_SUB, BY_DEC, BY_IOR, BY_AND, BY_XOR, BY_ADD,
		BY_MOV, BY_COM, BY_INC, BY_RR, BY_RL, BY_SWAP};
	logic [3:0] liops [5] = '{LI_IOR, LI_AND, LI_XOR, 4'hc, 4'he};
	logic [3:0] lialu [5] = '{BY_IOR, BY_AND, BY_XOR, BY_SUB, BY_ADD};
	logic [7:0] cna [4] = '{8'hff, 8'h10, 8'h00, 8'h0f};
	logic [7:0] cnb [4] = '{8'h01, 8'h10, 8'h01, 8'h01};
	logic [3:0] cno [4] = '{BY_ADD, BY_SUB, BY_SUB, BY_ADD};
	int ci [7] = '{5, 6, 7, 8, 10, 13, 16};
	logic [7:0] cv [7] = '{8'h35, 8'h20, 8'h00, 8'h09, 8'h20, 8'h66, 8'h1f};
	logic [13:0] fx [6] = '{14'h2001, 14'h2002, 14'h2003, 14'h0805, 14'h2806, 14'h2807};
	logic [7:0] rw [3] = '{8'h00, 8'h77, 8'h77};
	logic [7:0] rf [3] = '{8'h18, 8'h1f, 8'h1f};

	ccd_core #(.PROG_WORDS(8192), .DRAM_DEPTH(512)) ccd_core_inst (.CLK(clk), .RST(rst),
		.BOR_RST(bor_rst), .EXT_RST(ext_rst), .WDOG_RST(wdog_rst), .PROG_ADDR(prog_addr),
		.PROG_DATA(prog_data), .WREG(wreg), .FLAGS(flags), .EXEC_VALID(exec_valid));
	ccd_prog_model #(.WORDS(8192)) ccd_prog_model_inst (.addr(prog_addr), .data(prog_data));

	// The clock toggles every half period of 2.5 ns.
	always #2.5 clk = ~clk;

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one data byte.
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compares the execute flag together with the fetch address.
	task automatic chk_fetch(input string what, input logic [13:0] exp, input logic [13:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Instruction word builders.
	function automatic logic [13:0] bop(input logic [3:0] o, input logic d, input logic [6:0] f);
		return {GRP_BYTE, o, d, f};
	endfunction
	function automatic logic [13:0] lop(input logic [3:0] o, input logic [7:0] kv);
		return {GRP_LIT, o, kv};
	endfunction

	// Expected result and flags of one operation, starting with carry clear.
	function automatic void alu_model(input logic [3:0] o, input logic [7:0] f,
		input logic [7:0] w, output logic [7:0] y, output logic [2:0] fo, output logic [2:0] m);
		logic [8:0] s;
		s = 9'h000;
		m = 3'b100;
		fo = 3'b000;
		case (o)
			BY_ADD: begin
				s = {1'b0, f} + {1'b0, w};
				fo[0] = s[8];
				fo[1] = ({1'b0, f[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
				m = 3'b111;
			end
			BY_SUB: begin
				s = {1'b0, f - w};
				fo[0] = f >= w;
				fo[1] = f[3:0] >= w[3:0];
				m = 3'b111;
			end
			BY_DEC: s = {1'b0, f - 8'h01};
			BY_IOR: s = {1'b0, f | w};
			BY_AND: s = {1'b0, f & w};
			BY_XOR: s = {1'b0, f ^ w};
			BY_MOV: s = {1'b0, f};
			BY_COM: s = {1'b0, ~f};
			BY_INC: s = {1'b0, f + 8'h01};
			BY_RR: begin
				s = {2'b00, f[7:1]};
				fo[0] = f[0];
				m = 3'b001;
			end
			BY_RL: begin
				s = {1'b0, f[6:0], 1'b0};
				fo[0] = f[7];
				m = 3'b001;
			end
			BY_SWAP: begin
				s = {1'b0, f[3:0], f[7:4]};
				m = 3'b000;
			end
			default: s = 9'h000;
		endcase
		y = s[7:0];
		fo[2] = (y == 8'h00);
	endfunction

	// Clears program memory and places a program from address zero.
	task automatic load(input logic [13:0] p[$]);
		foreach (ccd_prog_model_inst.mem[i]) ccd_prog_model_inst.mem[i] = 14'h0000;
		foreach (p[i]) ccd_prog_model_inst.mem[i] = p[i];
	endtask

	// Applies power-on reset, then lets n edges pass after its release.
	task automatic run(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Cuts a hang short.
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end

	// Main sequence.
	initial begin
		void'($urandom(83));
		repeat (10) @(posedge clk);
		#1;
		chk8("wreg", W_POR, wreg);
		chk8("flags", FLAGS_POR, flags);
		chk_fetch("fetch", 14'h0000, {exec_valid, prog_addr});
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			ra = (i < 4) ? cna[i] : 8'($urandom);
			rb = (i < 4) ? cnb[i] : 8'($urandom);
			if (i >= 4 && $urandom_range(1, 0) == 1) begin
				k = $urandom_range(4, 0);
				op = lialu[k];
				load('{lop(4'h0, rb), lop(liops[k], ra)});
				run(3);
			end else begin
				op = (i < 4) ? cno[i] : byops[$urandom_range(12, 0)];
				load('{lop(4'h0, ra), bop(BY_MOVWF, 1'b1, 7'h20), lop(4'h0, rb),
					bop(op, 1'b0, 7'h20)});
				run(5);
			end
			alu_model(op, ra, rb, ey, fl, fm);
			ef = (FLAGS_POR & ~{5'h00, fm}) | {5'h00, fl & fm};
			chk8("wreg", ey, wreg);
			chk8("flags", ef, flags);
			$display("test alu %0d done", i);
		end
		load('{lop(4'h0, 8'h35), bop(BY_MOVWF, 1'b1, 7'h20), lop(4'h0, 8'h20),
			bop(BY_MOVWF, 1'b1, 7'h04), bop(BY_CLR, 1'b0, 7'h00), bop(BY_MOV, 1'b0, 7'h00),
			bop(BY_MOV, 1'b0, 7'h04), bop(BY_MOV, 1'b0, 7'h05), bop(BY_MOV, 1'b0, 7'h02),
			{GRP_BIT, BI_SET, 3'h5, 7'h03}, bop(BY_MOV, 1'b0, 7'h04), lop(4'h0, 8'h66),
			bop(BY_MOVWF, 1'b1, 7'h00), bop(BY_MOV, 1'b0, 7'h00), lop(4'h0, 8'hff),
			bop(BY_MOVWF, 1'b1, 7'h0a), bop(BY_MOV, 1'b0, 7'h0a)});
		for (int j = 0; j < 7; j++) begin
			run(ci[j] + 2);
			chk8("wreg", cv[j], wreg);
		end
		$display("test register map done");
		load('{lop(4'h0, 8'h08), bop(BY_MOVWF, 1'b1, 7'h0a), {GRP_JUMP, 1'b1, 11'h005},
			lop(4'h0, 8'hee)});
		ccd_prog_model_inst.mem[13'h805] = lop(4'h0, 8'h5a);
		run(0);
		for (int j = 0; j < 6; j++) begin
			@(posedge clk);
			#1;
			chk_fetch("fetch", fx[j], {exec_valid, prog_addr});
			if (j == 4) begin
				chk8("wreg", 8'h08, wreg);
			end
		end
		chk8("wreg", 8'h5a, wreg);
		load('{lop(4'h0, 8'h10), bop(BY_MOVWF, 1'b1, 7'h02)});
		run(3);
		chk_fetch("fetch", 14'h0010, {exec_valid, prog_addr});
		load('{lop(4'h0, 8'h01), bop(BY_MOVWF, 1'b1, 7'h21), bop(BY_DECSKP, 1'b1, 7'h21),
			lop(4'h0, 8'hee), {GRP_BIT, 2'h2, 3'h0, 7'h21}, lop(4'h0, 8'hee),
			{GRP_BIT, 2'h3, 3'h0, 7'h21}, bop(BY_INCSKP, 1'b1, 7'h21), lop(4'he, 8'h10),
			bop(BY_ADD, 1'b0, 7'h21), {GRP_BIT, BI_CLR, 3'h0, 7'h21}, bop(BY_ADD, 1'b0, 7'h21),
			lop(4'h4, 8'hee), {GRP_JUMP, 1'b0, 11'h3ff}});
		run(15);
		chk8("wreg", 8'h12, wreg);
		chk_fetch("fetch", 14'h200f, {exec_valid, prog_addr});
		$display("test branch done");
		load('{lop(4'h0, 8'hff), lop(4'he, 8'h01), {GRP_BIT, BI_SET, 3'h5, 7'h03},
			lop(4'h0, 8'h77)});
		for (int j = 0; j < 3; j++) begin
			run(6);
			@(posedge clk);
			{bor_rst, ext_rst, wdog_rst} <= 3'b100 >> j;
			repeat (2) @(posedge clk);
			#1;
			chk8("wreg", rw[j], wreg);
			chk8("flags", rf[j], flags);
			chk_fetch("fetch", 14'h0000, {exec_valid, prog_addr});
			@(posedge clk);
			{bor_rst, ext_rst, wdog_rst} <= 3'b000;
		end
		$display("test reset kinds done");
		complete_run();
	end
endmodule
`default_nettype wire
